/* File: common/pmp_pkg.sv */
// Constants shared by the port M / port P pin logic.
// Assumes a 32-bit Wishbone slave with byte addresses.
package pmp_pkg;
  // Port width
  localparam int unsigned PMP_W = 8;
  // Register byte offsets
  localparam logic [7:0] PMP_OFF_M_IN = 8'h00;
  localparam logic [7:0] PMP_OFF_M_DIR = 8'h04;
  localparam logic [7:0] PMP_OFF_M_DATA = 8'h08;
  localparam logic [7:0] PMP_OFF_P_DATA = 8'h0C;
  localparam logic [7:0] PMP_OFF_P_DIR = 8'h10;
  localparam logic [7:0] PMP_OFF_P_EDGE = 8'h14;
  localparam logic [7:0] PMP_OFF_P_STAT = 8'h18;
  localparam logic [7:0] PMP_OFF_P_MASK = 8'h1C;
  // Reset value of every stored byte
  localparam logic [7:0] PMP_RST_BYTE = 8'h00;
  // Answer for unmapped reads
  localparam logic [31:0] PMP_RD_NONE = 32'h0000_0000;
  // Field positions on port P
  localparam int unsigned PMP_BIT_PWM_IO = 7;
  localparam int unsigned PMP_BIT_PWM_HI = 6;
  localparam int unsigned PMP_BIT_PWM_LO = 3;
  localparam int unsigned PMP_BIT_ROUTED = 2;
  // Owner of the shared pin
  typedef enum logic [1:0] {
    PMP_OWN_GPIO,
    PMP_OWN_PWM,
    PMP_OWN_TIMER,
    PMP_OWN_SERIAL
  } pmp_owner_e;
endpackage

/* File: dv/pmp_pin_logic_tb.sv */
// Self-checking bench for the port M / port P pin logic.
// Assumes a classic Wishbone slave answering one cycle after a request.
`timescale 1ns/1ps
module pmp_pin_logic_tb;
  logic clk_sys = 1'b0; // 25 MHz system clock
  logic rst_n = 1'b0; // Active low reset
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, rd;
  logic wb_ack_o, irq;
  logic [7:0] m_pin, m_out, m_oe, p_pin, p_out, p_oe, p_buf;
  logic [7:0] m_ext = 8'h00, p_ext = 8'h00; // Board levels
  logic [7:0] pwm_en = 8'h00, pwm_out = 8'h00;
  logic pwm_sd = 1'b0, pwm7_oe = 1'b0;
  logic tim_en = 1'b0, tim = 1'b0, sci_en = 1'b0, sci = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  // Owner table for the shared pin: pwm, timer, serial enables
  logic [2:0] own_en [4] = '{3'b111, 3'b011, 3'b001, 3'b000};
  logic own_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  // Clock
  always #20 clk_sys = ~clk_sys;

  pmp_pin_logic dut_u (
    .clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_m_pin_in(m_pin),
    .port_m_pin_out(m_out), .port_m_pin_oe(m_oe), .port_p_pin_in(p_pin),
    .port_p_pin_out(p_out), .port_p_pin_oe(p_oe), .port_p_pin_buffered(p_buf),
    .pwm_channel_enable(pwm_en), .pwm_shutdown_enable(pwm_sd), .pwm_out(pwm_out),
    .pwm_pin7_drive(pwm7_oe), .routed_timer_output_enable(tim_en),
    .routed_timer_output(tim), .routed_serial_one_enable(sci_en),
    .routed_serial_one(sci), .irq(irq)
  );

  pmp_pin_model pins_u (
    .m_out(m_out), .m_oe(m_oe), .p_out(p_out), .p_oe(p_oe),
    .m_ext(m_ext), .p_ext(p_ext), .m_pin(m_pin), .p_pin(p_pin)
  );

  // Single bus cycle; held until the edge that samples ack high
  task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] d, input logic [3:0] sel);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'h00_0000, d};
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] d);
    bus(1'b1, adr, d, 4'h1);
  endtask

  // Compare one value, count it, report a mismatch
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Read a register and compare it
  task automatic rchk(input string what, input logic [7:0] adr, input logic [7:0] exp);
    bus(1'b0, adr, 8'h00, 4'h1);
    check(what, rd, {24'h00_0000, exp});
  endtask

  // Let pin changes pass the synchroniser and flag stages
  task automatic settle();
    repeat (5) @(posedge clk_sys);
  endtask

  // Verdict
  task automatic complete_run();
    $display("Counts: %0d checked, %0d mismatched", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    complete_run();
  end

  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    rchk("m_dir_rst", pmp_pkg::PMP_OFF_M_DIR, 8'h00);
    check("m_oe_rst", m_oe, 8'h00);
    m_ext <= 8'h96;
    settle();
    rchk("m_in_pins", pmp_pkg::PMP_OFF_M_IN, 8'h96);
    wr(pmp_pkg::PMP_OFF_M_DIR, 8'hFF);
    wr(pmp_pkg::PMP_OFF_M_DATA, 8'h5A);
    settle();
    check("m_oe_out", m_oe, 8'hFF);
    check("m_out_drv", m_out, 8'h5A);
    rchk("m_in_driven", pmp_pkg::PMP_OFF_M_IN, 8'h5A);
    wr(pmp_pkg::PMP_OFF_M_IN, 8'h00);
    rchk("m_dir_kept", pmp_pkg::PMP_OFF_M_DIR, 8'hFF);
    rchk("m_in_kept", pmp_pkg::PMP_OFF_M_IN, 8'h5A);
    wr(pmp_pkg::PMP_OFF_M_DIR, 8'hA5);
    rchk("m_dir_rw", pmp_pkg::PMP_OFF_M_DIR, 8'hA5);
    $display("test port_m done");
    // Mixed direction on port P
    p_ext <= 8'hC3;
    wr(pmp_pkg::PMP_OFF_P_DIR, 8'h0F);
    wr(pmp_pkg::PMP_OFF_P_DATA, 8'h3C);
    settle();
    check("p_oe_gpio", p_oe, 8'h0F);
    check("p_out_gpio", p_out & 8'h0F, 8'h0C);
    rchk("p_read_mix", pmp_pkg::PMP_OFF_P_DATA, 8'hCC);
    check("p_buf_pins", p_buf, 8'hCC);
    $display("test port_p_gpio done");
    // Pin 7 taken by shutdown, then by its channel
    pwm_out <= 8'hC8;
    pwm7_oe <= 1'b1;
    pwm_sd <= 1'b1;
    settle();
    check("p7_sd_out", p_out[7], 1'b1);
    check("p7_sd_oe", p_oe[7], 1'b1);
    pwm_sd <= 1'b0;
    pwm_en <= 8'h80;
    settle();
    check("p7_ch_out", p_out[7], 1'b1);
    pwm_en <= 8'h78;
    settle();
    check("p63_pwm", p_out & 8'h78, 8'h48);
    check("p7_back", p_oe[7], 1'b0);
    $display("test pwm done");
    // Shared pin priority, every owner
    wr(pmp_pkg::PMP_OFF_P_DATA, 8'h00);
    pwm_out <= 8'h04;
    sci <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      pwm_en <= {5'h00, own_en[k][2], 2'b00};
      tim_en <= own_en[k][1];
      sci_en <= own_en[k][0];
      settle();
      check("p2_owner", p_out[2], own_exp[k]);
    end
    $display("test shared_pin done");
    // Pin interrupts on an input and on an output pin
    wr(pmp_pkg::PMP_OFF_P_DIR, 8'h02);
    p_ext <= 8'h00;
    settle();
    wr(pmp_pkg::PMP_OFF_P_EDGE, 8'hFF);
    wr(pmp_pkg::PMP_OFF_P_MASK, 8'h00);
    wr(pmp_pkg::PMP_OFF_P_STAT, 8'hFF);
    rchk("stat_clear", pmp_pkg::PMP_OFF_P_STAT, 8'h00);
    p_ext <= 8'h01;
    wr(pmp_pkg::PMP_OFF_P_DATA, 8'h02);
    settle();
    rchk("stat_rise", pmp_pkg::PMP_OFF_P_STAT, 8'h03);
    check("irq_masked", irq, 1'b0);
    wr(pmp_pkg::PMP_OFF_P_MASK, 8'h01);
    settle();
    check("irq_on", irq, 1'b1);
    wr(pmp_pkg::PMP_OFF_P_STAT, 8'h01);
    settle();
    rchk("stat_w1c", pmp_pkg::PMP_OFF_P_STAT, 8'h02);
    check("irq_off", irq, 1'b0);
    wr(pmp_pkg::PMP_OFF_P_EDGE, 8'h00);
    wr(pmp_pkg::PMP_OFF_P_STAT, 8'h02);
    p_ext <= 8'h00;
    settle();
    rchk("stat_fall", pmp_pkg::PMP_OFF_P_STAT, 8'h01);
    check("irq_fall", irq, 1'b1);
    $display("test irq done");
    // Unmapped place and a write with no byte enable
    wr(8'h20, 8'hFF);
    rchk("unmapped", 8'h20, 8'h00);
    bus(1'b1, pmp_pkg::PMP_OFF_M_DIR, 8'h00, 4'h0);
    rchk("sel_off", pmp_pkg::PMP_OFF_M_DIR, 8'hA5);
    $display("test bus_edges done");
    complete_run();
  end
endmodule

/* File: dv/pmp_pin_model.sv */
// Board-side model of the port M and port P pins.
// Assumes the bench sets the board levels; the pins have no pull devices.
`timescale 1ns/1ps
module pmp_pin_model (
  input wire logic [7:0] m_out,
  input wire logic [7:0] m_oe,
  input wire logic [7:0] p_out,
  input wire logic [7:0] p_oe,
  input wire logic [7:0] m_ext,
  input wire logic [7:0] p_ext,
  output logic [7:0] m_pin,
  output logic [7:0] p_pin
);
  // Wire level: the device wins where it drives, the board elsewhere
  // Board levels are always driven, so a released pin never floats
  assign m_pin = (m_oe & m_out) | (~m_oe & m_ext);
  assign p_pin = (p_oe & p_out) | (~p_oe & p_ext);
endmodule

/* File: logic/pmp_pin_flag.sv */
// Sticky pin interrupt flag for one port P pin.
// Assumes pin is already synchronised to clk_sys.
`timescale 1ns/1ps
module pmp_pin_flag (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic rise_sel,
  input wire logic clear,
  output logic flag
);
  // Last pin level, for edge detect
  logic pin_d;
  // Edge of the selected polarity
  logic hit;

  assign hit = rise_sel ? (pin & ~pin_d) : (~pin & pin_d);

  // Delayed pin level
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_d <= 1'b0;
    end else begin
      pin_d <= pin;
    end
  end

  // Set wins over clear so no edge is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flag <= 1'b0;
    end else if (hit) begin
      flag <= 1'b1;
    end else if (clear) begin
      flag <= 1'b0;
    end
  end
endmodule

/* File: logic/pmp_pin_logic.sv */
// Port M and port P pin logic with a Wishbone register slave.
// Assumes peripheral enables and outputs come from clk_sys logic;
// pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps
//
// Behaviour
// - Port M input read returns buffered pins
// - Writes to port M input change nothing
// - Port M direction readable, writable, resets zero
// - GPIO output drives stored data bit
// - Port P read: output bit else pin
// - Pin 7 PWM on channel or shutdown
// - Pins 6-3 taken by enabled PWM
// - Pin 2: PWM, timer, serial, GPIO
// - Every port P pin can interrupt
module pmp_pin_logic (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] port_m_pin_in,
  output logic [7:0] port_m_pin_out,
  output logic [7:0] port_m_pin_oe,
  input wire logic [7:0] port_p_pin_in,
  output logic [7:0] port_p_pin_out,
  output logic [7:0] port_p_pin_oe,
  output logic [7:0] port_p_pin_buffered,
  input wire logic [7:0] pwm_channel_enable,
  input wire logic pwm_shutdown_enable,
  input wire logic [7:0] pwm_out,
  input wire logic pwm_pin7_drive,
  input wire logic routed_timer_output_enable,
  input wire logic routed_timer_output,
  input wire logic routed_serial_one_enable,
  input wire logic routed_serial_one,
  output logic irq
);
  // Synchronised pin levels
  logic [7:0] m_sync;
  logic [7:0] p_sync;
  // Stored registers
  logic [7:0] m_dir;
  logic [7:0] m_data;
  logic [7:0] p_data;
  logic [7:0] p_dir;
  logic [7:0] int_edge;
  logic [7:0] int_mask;
  // Sticky pin flags
  logic [7:0] int_stat;
  // Bus decode
  logic req;
  logic wr_take;
  logic [5:0] word;
  // Port P data readback
  logic [7:0] p_read;
  // Read mux result
  logic [31:0] next_rdata;
  // Pin drive before the output flops
  logic [7:0] next_p_out;
  logic [7:0] next_p_oe;
  // Owner of the shared pin 2
  pmp_pkg::pmp_owner_e own2;
  // Write-one-to-clear strobes
  logic [7:0] stat_clr;

  // Pins are asynchronous: two flops each
  pmp_sync2 #(
    .W(8)
  ) u_sync_m (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(port_m_pin_in),
    .q(m_sync)
  );

  pmp_sync2 #(
    .W(8)
  ) u_sync_p (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(port_p_pin_in),
    .q(p_sync)
  );

  // Buffered pin state for peripherals such as PWM input
  assign port_p_pin_buffered = p_sync;

  // Request seen; write lands on the acked edge only
  assign req = wb_cyc_i & wb_stb_i;
  assign word = wb_adr_i[7:2];
  assign wr_take = req & wb_we_i & wb_ack_o & wb_sel_i[0];

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
    end
  end

  // Readback of port P: stored bit for outputs, pin otherwise
  assign p_read = (p_dir & p_data) | (~p_dir & p_sync);

  // Read mux; unmapped words read zero
  always_comb begin
    next_rdata = pmp_pkg::PMP_RD_NONE;
    case (word)
      pmp_pkg::PMP_OFF_M_IN[7:2]: begin
        next_rdata[7:0] = m_sync;
      end
      pmp_pkg::PMP_OFF_M_DIR[7:2]: begin
        next_rdata[7:0] = m_dir;
      end
      pmp_pkg::PMP_OFF_M_DATA[7:2]: begin
        next_rdata[7:0] = m_data;
      end
      pmp_pkg::PMP_OFF_P_DATA[7:2]: begin
        next_rdata[7:0] = p_read;
      end
      pmp_pkg::PMP_OFF_P_DIR[7:2]: begin
        next_rdata[7:0] = p_dir;
      end
      pmp_pkg::PMP_OFF_P_EDGE[7:2]: begin
        next_rdata[7:0] = int_edge;
      end
      pmp_pkg::PMP_OFF_P_STAT[7:2]: begin
        next_rdata[7:0] = int_stat;
      end
      pmp_pkg::PMP_OFF_P_MASK[7:2]: begin
        next_rdata[7:0] = int_mask;
      end
      default: begin
        next_rdata = pmp_pkg::PMP_RD_NONE;
      end
    endcase
  end

  // Read data captured in the request cycle, held with ack
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_dat_o <= pmp_pkg::PMP_RD_NONE;
    end else if (req & ~wb_ack_o) begin
      wb_dat_o <= next_rdata;
    end
  end

  // Port M direction; input word has no write path at all
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m_dir <= pmp_pkg::PMP_RST_BYTE;
    end else if (wr_take && word == pmp_pkg::PMP_OFF_M_DIR[7:2]) begin
      m_dir <= wb_dat_i[7:0];
    end
  end

  // Port M output data
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      m_data <= pmp_pkg::PMP_RST_BYTE;
    end else if (wr_take && word == pmp_pkg::PMP_OFF_M_DATA[7:2]) begin
      m_data <= wb_dat_i[7:0];
    end
  end

  // Port P data, stored even while a peripheral owns the pin
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p_data <= pmp_pkg::PMP_RST_BYTE;
    end else if (wr_take && word == pmp_pkg::PMP_OFF_P_DATA[7:2]) begin
      p_data <= wb_dat_i[7:0];
    end
  end

  // Port P direction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      p_dir <= pmp_pkg::PMP_RST_BYTE;
    end else if (wr_take && word == pmp_pkg::PMP_OFF_P_DIR[7:2]) begin
      p_dir <= wb_dat_i[7:0];
    end
  end

  // Edge select and interrupt mask
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      int_edge <= pmp_pkg::PMP_RST_BYTE;
      int_mask <= pmp_pkg::PMP_RST_BYTE;
    end else if (wr_take) begin
      if (word == pmp_pkg::PMP_OFF_P_EDGE[7:2]) begin
        int_edge <= wb_dat_i[7:0];
      end
      if (word == pmp_pkg::PMP_OFF_P_MASK[7:2]) begin
        int_mask <= wb_dat_i[7:0];
      end
    end
  end

  // Clear strobes for the status word
  assign stat_clr = (wr_take && word == pmp_pkg::PMP_OFF_P_STAT[7:2]) ? wb_dat_i[7:0] : 8'h00;

  // One flag per pin, watching the pin level in any direction
  for (genvar i = 0; i < 8; i++) begin : g_flag
    pmp_pin_flag u_flag (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .pin(p_sync[i]),
      .rise_sel(int_edge[i]),
      .clear(stat_clr[i]),
      .flag(int_stat[i])
    );
  end

  // Level interrupt while an unmasked flag stands
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_stat & int_mask);
    end
  end

  // Pin 2 owner in fixed priority
  always_comb begin
    if (pwm_channel_enable[pmp_pkg::PMP_BIT_ROUTED]) begin
      own2 = pmp_pkg::PMP_OWN_PWM;
    end else if (routed_timer_output_enable) begin
      own2 = pmp_pkg::PMP_OWN_TIMER;
    end else if (routed_serial_one_enable) begin
      own2 = pmp_pkg::PMP_OWN_SERIAL;
    end else begin
      own2 = pmp_pkg::PMP_OWN_GPIO;
    end
  end

  // Port P drive: GPIO default, then peripheral overrides
  always_comb begin
    next_p_out = p_data;
    next_p_oe = p_dir;
    for (int i = pmp_pkg::PMP_BIT_PWM_LO; i <= pmp_pkg::PMP_BIT_PWM_HI; i++) begin
      if (pwm_channel_enable[i]) begin
        next_p_out[i] = pwm_out[i];
        next_p_oe[i] = 1'b1;
      end
    end
    // Pin 7 may be a PWM input, so PWM steers its enable
    if (pwm_channel_enable[pmp_pkg::PMP_BIT_PWM_IO] | pwm_shutdown_enable) begin
      next_p_out[pmp_pkg::PMP_BIT_PWM_IO] = pwm_out[pmp_pkg::PMP_BIT_PWM_IO];
      next_p_oe[pmp_pkg::PMP_BIT_PWM_IO] = pwm_pin7_drive;
    end
    case (own2)
      pmp_pkg::PMP_OWN_PWM: begin
        next_p_out[pmp_pkg::PMP_BIT_ROUTED] = pwm_out[pmp_pkg::PMP_BIT_ROUTED];
        next_p_oe[pmp_pkg::PMP_BIT_ROUTED] = 1'b1;
      end
      pmp_pkg::PMP_OWN_TIMER: begin
        next_p_out[pmp_pkg::PMP_BIT_ROUTED] = routed_timer_output;
        next_p_oe[pmp_pkg::PMP_BIT_ROUTED] = 1'b1;
      end
      pmp_pkg::PMP_OWN_SERIAL: begin
        next_p_out[pmp_pkg::PMP_BIT_ROUTED] = routed_serial_one;
        next_p_oe[pmp_pkg::PMP_BIT_ROUTED] = 1'b1;
      end
      default: begin
        next_p_out[pmp_pkg::PMP_BIT_ROUTED] = p_data[pmp_pkg::PMP_BIT_ROUTED];
        next_p_oe[pmp_pkg::PMP_BIT_ROUTED] = p_dir[pmp_pkg::PMP_BIT_ROUTED];
      end
    endcase
  end

  // Pin drivers registered; costs a cycle but avoids glitches on pads
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_p_pin_out <= pmp_pkg::PMP_RST_BYTE;
      port_p_pin_oe <= pmp_pkg::PMP_RST_BYTE;
      port_m_pin_out <= pmp_pkg::PMP_RST_BYTE;
      port_m_pin_oe <= pmp_pkg::PMP_RST_BYTE;
    end else begin
      port_p_pin_out <= next_p_out;
      port_p_pin_oe <= next_p_oe;
      port_m_pin_out <= m_data;
      port_m_pin_oe <= m_dir;
    end
  end

  // Checks

  // Read request phase on a given word
  sequence s_rd(logic [5:0] w);
    req && !wb_we_i && !wb_ack_o && word == w;
  endsequence

  // Write taken on a given word
  sequence s_wr(logic [5:0] w);
    wr_take && word == w;
  endsequence

  property p_rd_m_in;
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd(pmp_pkg::PMP_OFF_M_IN[7:2]) |=> wb_ack_o && wb_dat_o[7:0] == $past(m_sync);
  endproperty
  a_rd_m_in: assert property (p_rd_m_in) else $error("input read wrong");

  property p_wr_m_in;
    @(posedge clk_sys) disable iff (!rst_n)
    s_wr(pmp_pkg::PMP_OFF_M_IN[7:2]) |=> $stable(m_dir) && $stable(m_data) && $stable(p_data) && $stable(p_dir);
  endproperty
  a_wr_m_in: assert property (p_wr_m_in) else $error("input write changed state");

  property p_m_dir;
    @(posedge clk_sys) disable iff (!rst_n)
    s_wr(pmp_pkg::PMP_OFF_M_DIR[7:2]) |=> m_dir == $past(wb_dat_i[7:0]) ##1 port_m_pin_oe == $past(m_dir);
  endproperty
  a_m_dir: assert property (p_m_dir) else $error("direction not stored");

  property p_gpio_drive;
    @(posedge clk_sys) disable iff (!rst_n)
    (pwm_channel_enable == 8'h00 && !pwm_shutdown_enable && !routed_timer_output_enable
      && !routed_serial_one_enable) |=> port_p_pin_out == $past(p_data) && port_p_pin_oe == $past(p_dir);
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) else $error("gpio drive wrong");

  property p_rd_p;
    @(posedge clk_sys) disable iff (!rst_n)
    s_rd(pmp_pkg::PMP_OFF_P_DATA[7:2]) |=>
      wb_dat_o[7:0] == (($past(p_dir) & $past(p_data)) | (~$past(p_dir) & $past(p_sync)));
  endproperty
  a_rd_p: assert property (p_rd_p) else $error("port data read wrong");

  property p_pin7;
    @(posedge clk_sys) disable iff (!rst_n)
    (pwm_shutdown_enable | pwm_channel_enable[7]) |=> port_p_pin_out[7] == $past(pwm_out[7])
      && port_p_pin_oe[7] == $past(pwm_pin7_drive);
  endproperty
  a_pin7: assert property (p_pin7) else $error("pin 7 not PWM");

  property p_pin3;
    @(posedge clk_sys) disable iff (!rst_n)
    pwm_channel_enable[3] |=> port_p_pin_out[3] == $past(pwm_out[3]) && port_p_pin_oe[3];
  endproperty
  a_pin3: assert property (p_pin3) else $error("pin 3 not PWM");

  property p_pin2;
    @(posedge clk_sys) disable iff (!rst_n)
    (!pwm_channel_enable[2] && routed_timer_output_enable) |=>
      port_p_pin_out[2] == $past(routed_timer_output) && port_p_pin_oe[2];
  endproperty
  a_pin2: assert property (p_pin2) else $error("pin 2 priority wrong");

  property p_flag;
    @(posedge clk_sys) disable iff (!rst_n)
    (int_edge[0] && $rose(p_sync[0])) |=> int_stat[0];
  endproperty
  a_flag: assert property (p_flag) else $error("pin flag missed");

  property p_irq;
    @(posedge clk_sys) disable iff (!rst_n)
    (|(int_stat & int_mask)) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt not raised");
endmodule

/* File: logic/pmp_sync2.sv */
// Two-flop synchroniser for pin inputs.
// Assumes d is asynchronous to clk_sys.
`timescale 1ns/1ps
module pmp_sync2 #(
  parameter int unsigned W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta;

  // Both stages clear on reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
